//--- verilog/rcr_pkg.sv
// Shared constants and types for the rotate, carry-clear and return executor.
// Assumes a single core clock and an AXI4-Lite master for software access.
`default_nettype none

package rcr_pkg;

  // ==========================================================================
  // Opcodes (direct forms; the indirect form sets bit 0)
  localparam logic [7:0] OP_CLR_CARRY   = 8'hCF;
  localparam logic [7:0] OP_RETURN      = 8'hAF;
  localparam logic [7:0] OP_RL_DIR      = 8'h90;
  localparam logic [7:0] OP_RLC_DIR     = 8'h10;
  localparam logic [7:0] OP_RR_DIR      = 8'hE0;
  localparam logic [7:0] OP_RRC_DIR     = 8'hC0;
  localparam logic [7:0] OP_MODE_MASK   = 8'hFE;

  // ==========================================================================
  // Execution lengths in core cycles
  localparam logic [3:0] CYC_CLR_CARRY  = 4'h4;
  localparam logic [3:0] CYC_RETURN     = 4'h8;
  localparam logic [3:0] CYC_ROTATE     = 4'h4;
  localparam logic [15:0] RET_SP_STEP   = 16'h0002;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] REG_CTRL       = 8'h00;
  localparam logic [7:0] REG_STATUS     = 8'h04;
  localparam logic [7:0] REG_FLAGS      = 8'h08;
  localparam logic [7:0] REG_PC         = 8'h0C;
  localparam logic [7:0] REG_SP         = 8'h10;
  localparam logic [7:0] REG_MEM_INDEX  = 8'h14;
  localparam logic [7:0] REG_MEM_DATA   = 8'h18;

  // ==========================================================================
  // Field positions and reset values
  localparam int         CTRL_GO_BIT    = 31;
  localparam int         STAT_BUSY_BIT  = 0;
  localparam int         STAT_ILL_BIT   = 1;
  localparam logic [5:0] FLAGS_RESET    = 6'h00;
  localparam logic [15:0] PC_RESET      = 16'h0000;
  localparam logic [15:0] SP_RESET      = 16'h0000;
  localparam logic [1:0] RESP_OKAY      = 2'h0;
  localparam logic [1:0] RESP_SLVERR    = 2'h2;

  // FLAGS register bits 5..0 in this order
  typedef struct packed {
    logic c;
    logic z;
    logic s;
    logic v;
    logic d;
    logic h;
  } rcr_flags_type;

  typedef struct packed {
    logic [7:0] result;
    logic       carry;
  } rcr_rot_type;

  typedef enum logic [2:0] {
    KIND_NONE = 3'h0,
    KIND_CLR  = 3'h1,
    KIND_RET  = 3'h2,
    KIND_RL   = 3'h3,
    KIND_RLC  = 3'h4,
    KIND_RR   = 3'h5,
    KIND_RRC  = 3'h6
  } rcr_kind_type;

  typedef enum logic [1:0] {
    RCR_IDLE = 2'b01,
    RCR_RUN  = 2'b10
  } rcr_state_type;

endpackage

`default_nettype wire

//--- verilog/rcr_exec.sv
// Executor for carry clear, procedure return and the four byte rotates.
// Assumes an AXI4-Lite master on aclk; the operand bytes and the stack
// live in a small flip-flop byte store reached through MEM_INDEX/MEM_DATA.
//
// Overview of operation
// - Carry clear zeroes C, other flags kept.
// - Return loads PC from stack, SP plus two.
// - PC high from SP byte, low next.
// - Return leaves every flag untouched.
// - Left rotate: old bit7 to bit0, C.
// - Left through carry: C in, bit7 out.
// - Right rotate: old bit0 to bit7, C.
// - Right through carry: C in, bit0 out.
// - Rotates set Z when result is zero.
// - Rotates copy result bit7 into S.
// - Rotates set V when bit7 changed.
// - Rotates keep D and H unchanged.
//
// Local design decisions: the AXI4-Lite interface to the registers and the register offsets.
`default_nettype none

module rcr_exec
  import rcr_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int DEPTH  = 16
)(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);

  localparam int AW = $clog2(DEPTH);

  if (ADDR_W < 8 || DEPTH < 4 || DEPTH > 256 || (DEPTH & (DEPTH - 1)) != 0)
  begin : g_bad_params
    $error("rcr_exec: ADDR_W must be >= 8, DEPTH a power of two in 4..256");
  end

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] merge(input logic [31:0] old_val,
                                        input logic [31:0] new_val,
                                        input logic [3:0]  strb);
    logic [31:0] m;
    m = old_val;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        m[i*8 +: 8] = new_val[i*8 +: 8];
      end
    end
    return m;
  endfunction

  function automatic rcr_kind_type decode(input logic [7:0] op);
    rcr_kind_type k;
    k = KIND_NONE;
    case (op & OP_MODE_MASK)
      OP_RL_DIR:  k = KIND_RL;
      OP_RLC_DIR: k = KIND_RLC;
      OP_RR_DIR:  k = KIND_RR;
      OP_RRC_DIR: k = KIND_RRC;
      default:    k = KIND_NONE;
    endcase
    if (op == OP_CLR_CARRY)
    begin
      k = KIND_CLR;
    end
    if (op == OP_RETURN)
    begin
      k = KIND_RET;
    end
    return k;
  endfunction

  function automatic logic is_rotate(input rcr_kind_type k);
    return (k == KIND_RL) || (k == KIND_RLC) || (k == KIND_RR) || (k == KIND_RRC);
  endfunction

  function automatic rcr_rot_type rotate(input rcr_kind_type k,
                                         input logic [7:0]   val,
                                         input logic         cin);
    rcr_rot_type r;
    r.carry  = val[7];
    r.result = {val[6:0], val[7]};
    case (k)
      KIND_RLC: r.result = {val[6:0], cin};
      KIND_RR:
      begin
        r.carry  = val[0];
        r.result = {val[0], val[7:1]};
      end
      KIND_RRC:
      begin
        r.carry  = val[0];
        r.result = {cin, val[7:1]};
      end
      default: r.carry = val[7];
    endcase
    return r;
  endfunction

  // ==========================================================================
  // State
  rcr_state_type state;
  rcr_kind_type  cur_kind;
  logic [3:0]    count;
  logic [7:0]    cur_op;
  logic [7:0]    cur_dst;
  rcr_flags_type flags;
  logic [15:0]   pc;
  logic [15:0]   sp;
  logic [7:0]    mem [DEPTH];
  logic [AW-1:0] mem_index;
  logic [7:0]    last_result;
  logic [AW-1:0] last_target;
  logic          illegal;
  logic          aw_full;
  logic          w_full;
  logic [7:0]    aw_addr;
  logic [31:0]   w_data;
  logic [3:0]    w_strb;

  // ==========================================================================
  // Write channel: address and data are taken in either order
  wire logic        aw_take  = s_axi_awvalid && s_axi_awready;
  wire logic        w_take   = s_axi_wvalid && s_axi_wready;
  wire logic        wr_fire  = aw_full && w_full && !s_axi_bvalid;
  wire logic        next_aw_full = (aw_full && !wr_fire) || aw_take;
  wire logic        next_w_full  = (w_full && !wr_fire) || w_take;
  wire logic        idle     = (state == RCR_IDLE);

  wire logic        wa_ctrl  = (aw_addr == REG_CTRL);
  wire logic        wa_stat  = (aw_addr == REG_STATUS);
  wire logic        wa_flags = (aw_addr == REG_FLAGS);
  wire logic        wa_pc    = (aw_addr == REG_PC);
  wire logic        wa_sp    = (aw_addr == REG_SP);
  wire logic        wa_midx  = (aw_addr == REG_MEM_INDEX);
  wire logic        wa_mdat  = (aw_addr == REG_MEM_DATA);
  wire logic        wa_hit   = wa_ctrl || wa_stat || wa_flags || wa_pc || wa_sp
                               || wa_midx || wa_mdat;
  // Busy refuses writes so software cannot race the instruction in flight
  wire logic        wr_ok    = wr_fire && wa_hit && idle;

  wire logic [31:0] ctrl_new = merge({16'h0000, cur_dst, cur_op}, w_data, w_strb);
  wire logic [31:0] reg_new  = merge(32'h0000_0000, w_data, w_strb);
  wire logic        go       = wr_ok && wa_ctrl && ctrl_new[CTRL_GO_BIT];
  wire rcr_kind_type new_kind = decode(ctrl_new[7:0]);
  wire logic        start    = go && (new_kind != KIND_NONE);
  wire logic        ill_evt  = go && (new_kind == KIND_NONE);

  // ==========================================================================
  // Operand and stack fetch
  wire logic          done       = (state == RCR_RUN) && (count == 4'h0);
  wire logic          cur_ind    = cur_op[0];
  wire logic [AW-1:0] dst_idx    = cur_dst[AW-1:0];
  wire logic [7:0]    ptr_val    = mem[dst_idx];
  wire logic [AW-1:0] ptr_idx    = ptr_val[AW-1:0];
  wire logic [AW-1:0] target     = cur_ind ? ptr_idx : dst_idx;
  wire logic [7:0]    rot_in     = mem[target];
  wire logic          rot_in_msb = rot_in[7];
  wire logic          rot_in_lsb = rot_in[0];
  wire logic          carry_now  = flags.c;
  wire rcr_rot_type   rot        = rotate(cur_kind, rot_in, flags.c);
  wire logic          rot_done   = done && is_rotate(cur_kind);
  wire logic [15:0]   sp_plus1   = sp + 16'h0001;
  wire logic [15:0]   sp_plus2   = sp + RET_SP_STEP;
  wire logic [7:0]    stack_hi   = mem[sp[AW-1:0]];
  wire logic [7:0]    stack_lo   = mem[sp_plus1[AW-1:0]];

  wire logic [3:0]    new_cycles = (new_kind == KIND_RET) ? CYC_RETURN
                                 : (new_kind == KIND_CLR) ? CYC_CLR_CARRY : CYC_ROTATE;

  rcr_flags_type next_flags;
  always_comb
  begin
    next_flags = flags;
    if (wr_ok && wa_flags)
    begin
      next_flags = reg_new[5:0];
    end
    if (done && cur_kind == KIND_CLR)
    begin
      next_flags.c = 1'b0;
    end
    if (rot_done)
    begin
      next_flags.c = rot.carry;
      next_flags.z = (rot.result == 8'h00);
      next_flags.s = rot.result[7];
      next_flags.v = rot_in[7] ^ rot.result[7];
    end
  end

  // ==========================================================================
  // Sequencer
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state    <= RCR_IDLE;
      count    <= 4'h0;
      cur_kind <= KIND_NONE;
      cur_op   <= 8'h00;
      cur_dst  <= 8'h00;
    end
    else
    begin
      case (state)
        RCR_IDLE:
        begin
          if (start)
          begin
            state    <= RCR_RUN;
            count    <= new_cycles - 4'h1;
            cur_kind <= new_kind;
          end
          if (wr_ok && wa_ctrl)
          begin
            cur_op  <= ctrl_new[7:0];
            cur_dst <= ctrl_new[15:8];
          end
        end
        RCR_RUN:
        begin
          count <= count - 4'h1;
          if (done)
          begin
            state <= RCR_IDLE;
          end
        end
        default: state <= RCR_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Architectural state
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      flags       <= FLAGS_RESET;
      pc          <= PC_RESET;
      sp          <= SP_RESET;
      mem_index   <= '0;
      last_result <= 8'h00;
      last_target <= '0;
      illegal     <= 1'b0;
    end
    else
    begin
      flags <= next_flags;
      if (done && cur_kind == KIND_RET)
      begin
        pc <= {stack_hi, stack_lo};
        sp <= sp_plus2;
      end
      else
      begin
        if (wr_ok && wa_pc)
        begin
          pc <= reg_new[15:0];
        end
        if (wr_ok && wa_sp)
        begin
          sp <= reg_new[15:0];
        end
      end
      if (wr_ok && wa_midx)
      begin
        mem_index <= reg_new[AW-1:0];
      end
      if (rot_done)
      begin
        last_result <= rot.result;
        last_target <= target;
      end
      // A new illegal opcode wins over a clear in the same cycle
      if (ill_evt)
      begin
        illegal <= 1'b1;
      end
      else if (wr_ok && wa_stat && reg_new[STAT_ILL_BIT])
      begin
        illegal <= 1'b0;
      end
    end
  end

  // Only the rotated byte changes; the pointer byte is left alone
  always_ff @(posedge aclk)
  begin
    if (rot_done)
    begin
      mem[target] <= rot.result;
    end
    else if (wr_ok && wa_mdat)
    begin
      mem[mem_index] <= reg_new[7:0];
    end
  end

  // ==========================================================================
  // AXI write handshake and response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full       <= 1'b0;
      w_full        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end
    else
    begin
      aw_full       <= next_aw_full;
      w_full        <= next_w_full;
      s_axi_awready <= !next_aw_full;
      s_axi_wready  <= !next_w_full;
      if (aw_take)
      begin
        aw_addr <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (w_take)
      begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wa_hit && idle) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // AXI read path
  wire logic [7:0] ra = {s_axi_araddr[7:2], 2'b00};
  logic [31:0] rd_data;
  logic        rd_hit;
  always_comb
  begin
    rd_hit  = 1'b1;
    rd_data = 32'h0000_0000;
    if (ra == REG_CTRL)
    begin
      rd_data = {16'h0000, cur_dst, cur_op};
    end
    else if (ra == REG_STATUS)
    begin
      rd_data = {16'h0000, last_result, 6'h00, illegal, !idle};
    end
    else if (ra == REG_FLAGS)
    begin
      rd_data = {26'h0, flags};
    end
    else if (ra == REG_PC)
    begin
      rd_data = {16'h0000, pc};
    end
    else if (ra == REG_SP)
    begin
      rd_data = {16'h0000, sp};
    end
    else if (ra == REG_MEM_INDEX)
    begin
      rd_data[AW-1:0] = mem_index;
    end
    else if (ra == REG_MEM_DATA)
    begin
      rd_data[7:0] = mem[mem_index];
    end
    else
    begin
      rd_hit = 1'b0;
    end
  end

  wire logic ar_take     = s_axi_arvalid && s_axi_arready;
  wire logic next_rvalid = ar_take || (s_axi_rvalid && !s_axi_rready);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end
    else
    begin
      s_axi_rvalid  <= next_rvalid;
      s_axi_arready <= !next_rvalid;
      if (ar_take)
      begin
        s_axi_rdata <= rd_data;
        s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  wire rcr_kind_type start_kind = start ? new_kind : KIND_NONE;

  AST_CLR_CARRY: assert property (done && cur_kind == KIND_CLR |=>
    !flags.c && ((flags & 6'h1F) == ($past(flags) & 6'h1F)))
    else $error("carry clear left C set or touched other flags");
  AST_RET_LEN: assert property (start_kind == KIND_RET |=>
    (state == RCR_RUN) [*8] ##1 (state == RCR_IDLE))
    else $error("return did not take eight cycles");
  AST_RET_SP: assert property (done && cur_kind == KIND_RET |=>
    sp == $past(sp_plus2) && sp != $past(sp))
    else $error("return did not advance SP by two");
  AST_RET_PC: assert property (done && cur_kind == KIND_RET |=>
    pc == {$past(stack_hi), $past(stack_lo)})
    else $error("return loaded PC bytes wrongly");
  AST_RET_FLAGS: assert property (done && cur_kind == KIND_RET |=> $stable(flags))
    else $error("return changed a flag");
  AST_ROT_LEN: assert property (is_rotate(start_kind) |=>
    (state == RCR_RUN) [*4] ##1 (state == RCR_IDLE))
    else $error("rotate did not take four cycles");
  AST_RL: assert property (done && cur_kind == KIND_RL |=>
    flags.c == $past(rot_in_msb) && last_result[0] == $past(rot_in_msb))
    else $error("left rotate bit 7 not fed to C and bit 0");
  AST_RLC: assert property (done && cur_kind == KIND_RLC |=>
    flags.c == $past(rot_in_msb) && last_result[0] == $past(carry_now))
    else $error("left rotate through carry wrong");
  AST_RR: assert property (done && cur_kind == KIND_RR |=>
    flags.c == $past(rot_in_lsb) && last_result[7] == $past(rot_in_lsb))
    else $error("right rotate bit 0 not fed to C and bit 7");
  AST_RRC: assert property (done && cur_kind == KIND_RRC |=>
    flags.c == $past(rot_in_lsb) && last_result[7] == $past(carry_now))
    else $error("right rotate through carry wrong");
  AST_ZERO: assert property (rot_done |=> flags.z == (last_result == 8'h00))
    else $error("zero flag does not match result");
  AST_SIGN: assert property (rot_done |=> flags.s == last_result[7])
    else $error("sign flag does not match result bit 7");
  AST_OVF: assert property (rot_done |=> flags.v == ($past(rot_in_msb) ^ last_result[7]))
    else $error("overflow flag does not track bit 7 change");
  AST_DH_KEEP: assert property (rot_done |=>
    (flags & 6'h03) == ($past(flags) & 6'h03))
    else $error("rotate changed D or H");
  AST_INDIRECT: assert property (rot_done && cur_ind && ptr_idx != dst_idx |=>
    last_target == $past(ptr_idx) && mem[$past(dst_idx)] == $past(ptr_val))
    else $error("indirect rotate used wrong register or moved the pointer");

  COV_RET: cover property (done && cur_kind == KIND_RET);
  COV_RL_IND: cover property (rot_done && cur_kind == KIND_RL && cur_ind);
  COV_RRC_DIR: cover property (rot_done && cur_kind == KIND_RRC && !cur_ind);
  COV_ILLEGAL: cover property (ill_evt);

endmodule

`default_nettype wire

//--- tb/tb_rcr_exec.sv
// Self-checking bench for the rotate, carry-clear and return executor.
// Drives the AXI4-Lite slave port itself; a monitor checks queued notes.
`default_nettype none

module tb_rcr_exec import rcr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================================
  // Signals and bookkeeping
  logic        aclk, aresetn;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [33:0] rq[$];
  logic [1:0]  bq[$];
  int          err_total = 0;
  int          tests_run = 0;
  logic [31:0] seed = 32'h000184B4;

  rcr_exec #(.ADDR_W(8), .DEPTH(16)) i_dut
  (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready
  );

  initial
  begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic rcr_rot_type rot(input logic [7:0] op, input logic [7:0] v,
                                      input logic c);
    case (op & OP_MODE_MASK)
      OP_RL_DIR:  return '{{v[6:0], v[7]}, v[7]};
      OP_RLC_DIR: return '{{v[6:0], c}, v[7]};
      OP_RR_DIR:  return '{{v[0], v[7:1]}, v[0]};
      default:    return '{{c, v[7:1]}, v[0]};
    endcase
  endfunction

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("FAIL at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Monitor: oldest note against each response as it is accepted
  always @(posedge aclk)
  begin
    if (s_axi_rvalid && s_axi_rready)
      chk({s_axi_rresp, s_axi_rdata}, rq.pop_front());
    if (s_axi_bvalid && s_axi_bready)
      chk({32'h0, s_axi_bresp}, {32'h0, bq.pop_front()});
  end

  // Leading edge wait keeps a ready from being lowered and raised in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r = RESP_OKAY);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    bq.push_back(r);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!done)
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
      begin
        s_axi_bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r = RESP_OKAY);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    rq.push_back({r, d});
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    while (!done)
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
      begin
        s_axi_rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  task automatic sm(input logic [3:0] i, input logic [7:0] v);
    wr(REG_MEM_INDEX, {28'h0, i});
    wr(REG_MEM_DATA, {24'h0, v});
  endtask

  task automatic cm(input logic [3:0] i, input logic [7:0] v);
    wr(REG_MEM_INDEX, {28'h0, i});
    rd(REG_MEM_DATA, {24'h0, v});
  endtask

  // ==========================================================================
  // Main sequence
  initial
  begin
    logic [7:0]  ops[8];
    logic [7:0]  v;
    logic [3:0]  p, t;
    logic [5:0]  fl;
    logic [15:0] w16;
    rcr_rot_type rr;
    ops = '{8'h90, 8'h91, 8'h10, 8'h11, 8'hE0, 8'hE1, 8'hC0, 8'hC1};
    aresetn = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(REG_FLAGS, 32'h0);
    rd(REG_PC, 32'h0);
    rd(REG_SP, 32'h0);
    rd(REG_STATUS, 32'h0);
    rd(8'h1C, 32'h0, RESP_SLVERR);
    wr(8'h20, 32'h1, RESP_SLVERR);
    // Rotates, direct and indirect, sign-boundary and zero operands first
    foreach (ops[k])
      for (int j = 0; j < 4; j++)
      begin
        v = (j == 0) ? 8'h80 : (j == 1) ? 8'h00 : 8'(rnd());
        fl = 6'(rnd());
        p = 4'(rnd());
        t = ops[k][0] ? p ^ (4'(j) + 4'h1) : p;
        wr(REG_FLAGS, {26'h0, fl});
        if (ops[k][0])
          sm(p, {4'h0, t});
        sm(t, v);
        wr(REG_CTRL, {16'h8000, 4'h0, p, ops[k]});
        repeat (4) @(posedge aclk);
        rr = rot(ops[k], v, fl[5]);
        fl = {rr.carry, rr.result == 8'h00, rr.result[7], v[7] ^ rr.result[7], fl[1:0]};
        rd(REG_FLAGS, {26'h0, fl});
        cm(t, rr.result);
        if (ops[k][0])
          cm(p, {4'h0, t});
        rd(REG_STATUS, {16'h0, rr.result, 8'h00});
      end
    // Carry clear from both carry states
    for (int j = 0; j < 2; j++)
    begin
      fl = {j[0], 5'(rnd())};
      wr(REG_FLAGS, {26'h0, fl});
      wr(REG_CTRL, {24'h800000, OP_CLR_CARRY});
      repeat (4) @(posedge aclk);
      rd(REG_FLAGS, {26'h0, 1'b0, fl[4:0]});
    end
    // Unknown opcode: no start, sticky flag until software clears it
    v = 8'(rnd());
    wr(REG_CTRL, {16'h8000, v, 8'h00});
    rd(REG_CTRL, {16'h0, v, 8'h00});
    rd(REG_STATUS, {16'h0, rr.result, 8'h02});
    wr(REG_STATUS, 32'h2);
    rd(REG_STATUS, {16'h0, rr.result, 8'h00});
    // Strobes: only the operand byte lands, go stays clear
    s_axi_wstrb <= 4'h2;
    wr(REG_CTRL, 32'hFFFF_A5FF);
    s_axi_wstrb <= 4'hF;
    rd(REG_CTRL, 32'h0000_A500);
    // Return with the low byte wrapping round the store
    fl = 6'(rnd());
    w16 = 16'(rnd());
    wr(REG_FLAGS, {26'h0, fl});
    wr(REG_SP, 32'h0000000F);
    sm(4'hF, w16[15:8]);
    sm(4'h0, w16[7:0]);
    wr(REG_CTRL, {24'h800000, OP_RETURN});
    wr(REG_FLAGS, 32'h0, RESP_SLVERR);
    rd(REG_STATUS, {16'h0, rr.result, 8'h01});
    repeat (8) @(posedge aclk);
    rd(REG_PC, {16'h0, w16});
    rd(REG_SP, 32'h00000011);
    rd(REG_FLAGS, {26'h0, fl});
    repeat (2) @(posedge aclk);
    summarize();
  end

  // Roughly 1400 cycles expected; generous margin before giving up
  initial
  begin
    repeat (20000) @(posedge aclk);
    err_total++;
    summarize();
  end
endmodule

`default_nettype wire
